// *** logic/eeprom_slave_consts.svh ***
/*
 * Constants for the two-wire EEPROM slave: address byte fields, array
 * geometry and programming time.
 * Assumes a 20 MHz system clock.
 */
`ifndef EEPROM_SLAVE_CONSTS_SVH
`define EEPROM_SLAVE_CONSTS_SVH

`define TYPE_ID            4'ha
`define ID_MSB             7
`define ID_LSB             4
`define STRAP_HIGH_BIT     3
`define STRAP_LOW_BIT      2
`define WORD_MSB_BIT       1
`define RW_BIT             0
`define PAGE_COUNT         32
`define PAGE_BYTES         16
`define MEM_BYTES          512
`define CLK_MHZ            20
`define PROGRAM_CYCLE_US   5000
`define PROGRAM_CYCLES     (`PROGRAM_CYCLE_US * `CLK_MHZ)

`endif

// *** logic/eeprom_slave_pkg.sv ***
/*
 * Types shared by the two-wire EEPROM slave.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package eeprom_slave_pkg;
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_DEV_ADDR,
        ST_WORD_ADDR,
        ST_DATA,
        ST_READ,
        ST_IGNORE,
        ST_PROGRAM
    } slave_state_t;
endpackage
`default_nettype wire

// *** logic/page_fifo.sv ***
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module page_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////
    // Handshakes
    assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign out_data_o  = mem_ff[rd_ptr_ff];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule // page_fifo
`default_nettype wire

// *** logic/eeprom_array.sv ***
/*
 * Byte array of the EEPROM with a page latch. Bytes are loaded into the
 * latch, then programmed to the array during a self-timed cycle.
 * Assumes the caller starts programming only when the latch holds data.
 */
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_slave_consts.svh"
module eeprom_array #(
    parameter int MEM_BYTES  = `MEM_BYTES,
    parameter int PAGE_BYTES = `PAGE_BYTES,
    parameter int PROG_CYCLES = `PROGRAM_CYCLES
) (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Page latch load
    input  wire logic                          load_valid_i,
    output logic                               load_ready_o,
    input  wire logic [$clog2(MEM_BYTES)+7:0]  load_data_i,
    // Programming
    input  wire logic                          prog_start_i,
    output logic                               prog_busy_o,
    // Read port
    input  wire logic [$clog2(MEM_BYTES)-1:0]  rd_addr_i,
    output logic [7:0]                         rd_data_o
);
    localparam int AW = $clog2(MEM_BYTES);

    logic [7:0]  mem_ff [MEM_BYTES];
    logic [31:0] timer_ff;
    logic        busy_ff;
    logic        drain_valid;
    logic        drain_ready;
    logic [AW+7:0] drain_data;

    assign prog_busy_o = busy_ff;
    assign rd_data_o   = mem_ff[rd_addr_i];
    assign drain_ready = busy_ff && (timer_ff != '0);

    ////////////////////////////////////////////////////////////////////////
    // Page latch: address and data of each loaded byte
    page_fifo #(.WIDTH(AW+8), .DEPTH(PAGE_BYTES)) u_latch (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (load_valid_i),
        .in_ready_o  (load_ready_o),
        .in_data_i   (load_data_i),
        .out_valid_o (drain_valid),
        .out_ready_i (drain_ready),
        .out_data_o  (drain_data)
    );

    // Program latched bytes while the cycle runs
    always_ff @(posedge clk_i) begin
        if (drain_valid && drain_ready) begin
            mem_ff[drain_data[AW+7:8]] <= drain_data[7:0];
        end
    end

    // Self-timed programming cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_ff  <= 1'b0;
            timer_ff <= '0;
        end else if (prog_start_i && !busy_ff) begin
            busy_ff  <= 1'b1;
            timer_ff <= 32'(PROG_CYCLES - 1);
        end else if (busy_ff) begin
            if (timer_ff == '0) begin
                busy_ff <= 1'b0;
            end else begin
                timer_ff <= timer_ff - 1'b1;
            end
        end
    end
endmodule // eeprom_array
`default_nettype wire

// *** logic/two_wire_eeprom_slave.sv ***
/*
 * Slave protocol engine of a 512-byte two-wire serial EEPROM: Start/Stop
 * detection, address decode, acknowledge, byte/page write and the
 * self-timed programming cycle.
 * Assumes SCL and SDA arrive asynchronously and are oversampled by clk_i;
 * SDA is open drain, resolved outside from sda_oe_o.
 */
// Notes on behaviour
// RL1: Transmitter releases SDA after bit eight; receiver holds SDA low through ack.
// RL2: On master NACK after a sent byte, the device releases SDA.
// RL3: Acknowledging party releases SDA at the end of the ninth clock.
// RL4: Standby after reset, after Stop without write, and after programming.
// RL5: Dummy clocks within nine must let the device release SDA.
// RL6: Array is 32 pages of 16 bytes, 512 locations.
// RL7: Respond only when address byte bits 7..4 equal 1010.
// RL8: Address bits 3 and 2 are compared to the two strap pins.
// RL9: Address byte bit 1 is the word address MSB.
// RL10: Address bit 0 high means read, low means write.
// RL11: Acknowledge a matching address byte, not a mismatching one.
// RL12: Word address byte carries the low eight address bits.
// RL13: Master writes: Start, address with write bit, word address, data.
// RL14: Byte write acked throughout; Stop starts the self-timed program cycle.
// RL15: During programming, ignore the bus and acknowledge nothing.
// RL16: Page write takes up to 16 bytes; programming starts at Stop.
// RL17: Only the low four address bits increment, wrapping within the page.
// RL18: Master should avoid wrapping past the page end.
// RL19: Start is SDA fall with SCL high; Stop is SDA rise with SCL high.
// RL20: Sample on SCL rise, drive after SCL fall, MSB first.
// RL21: After an address mismatch, stay released until the next Start.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_slave_consts.svh"
module two_wire_eeprom_slave
    import eeprom_slave_pkg::*;
#(
    parameter int PROGRAM_CYCLES = `PROGRAM_CYCLES
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Straps
    input  wire logic strap_addr_high_i,
    input  wire logic strap_addr_low_i,
    // Two-wire bus
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    // Status
    output logic      standby_o,
    output logic      busy_o
);
    localparam int AW = $clog2(`MEM_BYTES);

    slave_state_t   state_ff;
    logic [1:0]     scl_sync_ff;
    logic [1:0]     sda_sync_ff;
    logic           scl_q_ff;
    logic           sda_q_ff;
    logic [7:0]     shift_ff;
    logic [3:0]     bit_cnt_ff;
    logic           ack_phase_ff;
    logic           drive_low_ff;
    logic           sda_oe_ff;
    logic           standby_ff;
    logic           busy_ff;
    logic           loaded_ff;
    logic           prog_start_ff;
    logic [AW-1:0]  word_addr_ff;
    logic [7:0]     tx_ff;
    logic           rd_addr_ack_ff;
    logic [1:0]     strap_hi_sync_ff;
    logic [1:0]     strap_lo_sync_ff;
    logic           master_nack_ff;
    logic           scl_s;
    logic           sda_s;
    logic           scl_rise;
    logic           scl_fall;
    logic           start_det;
    logic           stop_det;
    logic           addr_match;
    logic [7:0]     rx_byte;
    logic           byte_done;
    logic           load_valid;
    logic           load_ready;
    logic           prog_busy;
    logic [7:0]     rd_data;

    // Next word address within the same page
    function automatic logic [AW-1:0] page_inc(input logic [AW-1:0] a);
        return {a[AW-1:4], a[3:0] + 4'h1}; // [RL17]
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge finders
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_sync_ff      <= 2'h3;
            sda_sync_ff      <= 2'h3;
            strap_hi_sync_ff <= 2'h0;
            strap_lo_sync_ff <= 2'h0;
            scl_q_ff    <= 1'b1;
            sda_q_ff    <= 1'b1;
        end else begin
            scl_sync_ff      <= {scl_sync_ff[0], scl_i};
            sda_sync_ff      <= {sda_sync_ff[0], sda_i};
            strap_hi_sync_ff <= {strap_hi_sync_ff[0], strap_addr_high_i};
            strap_lo_sync_ff <= {strap_lo_sync_ff[0], strap_addr_low_i};
            scl_q_ff    <= scl_sync_ff[1];
            sda_q_ff    <= sda_sync_ff[1];
        end
    end

    assign scl_s     = scl_sync_ff[1];
    assign sda_s     = sda_sync_ff[1];
    assign scl_rise  = scl_s && !scl_q_ff;                           // [RL20]
    assign scl_fall  = !scl_s && scl_q_ff;
    assign start_det = scl_s && scl_q_ff && sda_q_ff && !sda_s;      // [RL19]
    assign stop_det  = scl_s && scl_q_ff && !sda_q_ff && sda_s;      // [RL19]

    // Byte assembly and address decode
    assign rx_byte    = {shift_ff[6:0], sda_s};
    assign byte_done  = scl_rise && !ack_phase_ff && (bit_cnt_ff == 4'h7);
    assign addr_match = (rx_byte[`ID_MSB:`ID_LSB] == `TYPE_ID)        // [RL7]
                     && (rx_byte[`STRAP_HIGH_BIT] == strap_hi_sync_ff[1]) // [RL8]
                     && (rx_byte[`STRAP_LOW_BIT] == strap_lo_sync_ff[1]);  // [RL8]
    assign load_valid = byte_done && (state_ff == ST_DATA);
    assign busy_o     = busy_ff;
    assign standby_o  = standby_ff;
    assign sda_o      = 1'b0;
    assign sda_oe_o   = sda_oe_ff;

    ////////////////////////////////////////////////////////////////////////
    // Memory with page latch and self-timed programming
    eeprom_array #(
        .MEM_BYTES   (`MEM_BYTES),     // [RL6]
        .PAGE_BYTES  (`PAGE_BYTES),
        .PROG_CYCLES (PROGRAM_CYCLES)
    ) u_array (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .load_valid_i (load_valid),
        .load_ready_o (load_ready),
        .load_data_i  ({word_addr_ff, rx_byte}),
        .prog_start_i (prog_start_ff),
        .prog_busy_o  (prog_busy),
        .rd_addr_i    (word_addr_ff),
        .rd_data_o    (rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bit counter and ack phase
    always_ff @(posedge clk_i) begin
        if (rst_i || start_det || stop_det) begin
            bit_cnt_ff   <= 4'h0;
            ack_phase_ff <= 1'b0;
        end else if (scl_rise) begin
            if (ack_phase_ff) begin
                ack_phase_ff <= 1'b0;
                bit_cnt_ff   <= 4'h0;
            end else if (bit_cnt_ff == 4'h7) begin
                ack_phase_ff <= 1'b1;
            end else begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
        end
    end

    // Shift register, MSB first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_ff <= 8'h00;
        end else if (scl_rise && !ack_phase_ff) begin
            shift_ff <= rx_byte;                                     // [RL20]
        end
    end

    // Protocol state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff      <= ST_STANDBY;
            loaded_ff     <= 1'b0;
            prog_start_ff <= 1'b0;
            word_addr_ff  <= '0;
        end else begin
            prog_start_ff <= 1'b0;
            unique case (state_ff)
                ST_PROGRAM: begin
                    // Bus is ignored while the cycle runs
                    if (!prog_busy && !prog_start_ff) begin          // [RL15]
                        state_ff <= ST_STANDBY;                      // [RL4]
                    end
                end
                default: begin
                    if (start_det) begin
                        state_ff  <= ST_DEV_ADDR;
                        loaded_ff <= 1'b0;
                    end else if (stop_det) begin
                        if (loaded_ff) begin
                            prog_start_ff <= 1'b1;                   // [RL14] [RL16]
                            state_ff      <= ST_PROGRAM;
                        end else begin
                            state_ff <= ST_STANDBY;                  // [RL4]
                        end
                        loaded_ff <= 1'b0;
                    end else if (byte_done) begin
                        unique case (state_ff)
                            ST_DEV_ADDR: begin
                                if (!addr_match) begin
                                    state_ff <= ST_IGNORE;           // [RL21]
                                end else if (rx_byte[`RW_BIT]) begin // [RL10]
                                    state_ff <= ST_READ;
                                end else begin
                                    state_ff <= ST_WORD_ADDR;
                                    word_addr_ff[AW-1] <= rx_byte[`WORD_MSB_BIT]; // [RL9]
                                end
                            end
                            ST_WORD_ADDR: begin
                                word_addr_ff[7:0] <= rx_byte;        // [RL12]
                                state_ff <= ST_DATA;
                            end
                            ST_DATA: begin
                                if (load_ready) begin
                                    loaded_ff <= 1'b1;
                                end
                                word_addr_ff <= page_inc(word_addr_ff); // [RL17]
                            end
                            default: begin
                            end
                        endcase
                    end else if (state_ff == ST_READ && scl_rise && ack_phase_ff) begin
                        word_addr_ff <= word_addr_ff + 1'b1;
                    end
                end
            endcase
        end
    end

    // Master acknowledge sampled in the ninth clock of a sent byte
    always_ff @(posedge clk_i) begin
        if (rst_i || start_det) begin
            master_nack_ff <= 1'b0;
        end else if (state_ff == ST_READ && scl_rise && ack_phase_ff) begin
            master_nack_ff <= sda_s;                                 // [RL2]
        end
    end

    // Marks the address byte of a read: the only read byte the device acknowledges
    always_ff @(posedge clk_i) begin
        if (rst_i || start_det || stop_det) begin
            rd_addr_ack_ff <= 1'b0;
        end else if (byte_done && state_ff == ST_DEV_ADDR) begin
            rd_addr_ack_ff <= rx_byte[`RW_BIT];                      // [RL10]
        end else if (scl_rise && ack_phase_ff) begin
            rd_addr_ack_ff <= 1'b0;                                  // [RL1]
        end
    end

    // Transmit byte for the minimal read path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_ff <= 8'h00;
        end else if (byte_done && state_ff == ST_DEV_ADDR) begin
            tx_ff <= rd_data;
        end else if (state_ff == ST_READ && scl_rise && ack_phase_ff) begin
            tx_ff <= rd_data;
        end else if (state_ff == ST_READ && scl_rise && !ack_phase_ff) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end

    // SDA driver: ack low through the ninth clock, released at its end
    always_ff @(posedge clk_i) begin
        if (rst_i || start_det || stop_det || state_ff == ST_PROGRAM) begin
            drive_low_ff <= 1'b0;                                    // [RL15]
        end else if (scl_fall) begin
            if (ack_phase_ff && bit_cnt_ff == 4'h7 &&
                (state_ff != ST_READ || rd_addr_ack_ff) &&
                state_ff != ST_IGNORE && state_ff != ST_STANDBY) begin
                drive_low_ff <= 1'b1;                                // [RL1] [RL11] [RL14]
            end else if (state_ff == ST_READ && !ack_phase_ff && !master_nack_ff) begin
                drive_low_ff <= !tx_ff[7];                           // [RL20]
            end else begin
                drive_low_ff <= 1'b0;                                // [RL1] [RL2] [RL3] [RL5]
            end
        end
    end

    // Registered pin enable and status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sda_oe_ff  <= 1'b0;
            standby_ff <= 1'b1;                                      // [RL4]
            busy_ff    <= 1'b0;
        end else begin
            sda_oe_ff  <= drive_low_ff;
            standby_ff <= (state_ff == ST_STANDBY);                  // [RL4]
            busy_ff    <= (state_ff == ST_PROGRAM);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_NO_DRIVE_PROG: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_ff |-> !sda_oe_ff) else $error("SDA driven while programming"); // [RL15]
    AST_BADID_NO_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
        (byte_done && state_ff == ST_DEV_ADDR && !addr_match)
        |=> state_ff == ST_IGNORE) else $error("Mismatch not ignored"); // [RL11]
    AST_STOP_PROGRAMS: assert property (@(posedge clk_i) disable iff (rst_i)
        (stop_det && loaded_ff && state_ff != ST_PROGRAM) |=> prog_start_ff)
        else $error("Stop did not start programming"); // [RL14]
    AST_STOP_STANDBY: assert property (@(posedge clk_i) disable iff (rst_i)
        (stop_det && !loaded_ff && state_ff != ST_PROGRAM) |=> ##1 standby_ff)
        else $error("Stop did not enter standby"); // [RL4]
    AST_PAGE_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
        (load_valid && !start_det && !stop_det) |=>
        word_addr_ff[AW-1:4] == $past(word_addr_ff[AW-1:4]))
        else $error("Page bits changed"); // [RL17]
    AST_IGNORE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_ff == ST_IGNORE && !start_det) |=> state_ff != ST_DEV_ADDR)
        else $error("Left ignore without Start"); // [RL21]
    AST_ACK_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
        (scl_fall && ack_phase_ff == 1'b0 && bit_cnt_ff == 4'h0 && state_ff != ST_READ)
        |=> ##1 !sda_oe_ff) else $error("SDA held after ack"); // [RL3]
    AST_WORD_MSB: assert property (@(posedge clk_i) disable iff (rst_i)
        (byte_done && state_ff == ST_DEV_ADDR && addr_match && !rx_byte[0] && !start_det
         && !stop_det) |=> word_addr_ff[AW-1] == $past(rx_byte[1]))
        else $error("Word MSB not taken"); // [RL9]
endmodule // two_wire_eeprom_slave
`default_nettype wire

// *** dv/bus_master_model.sv ***
/* Behavioural two-wire bus master that drives the EEPROM slave.
   Assumes the bench resolves SDA as open drain with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    // Clock
    input  wire logic clk_i,
    // Two-wire bus
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
////////////////////////////////////////
    // Idle bus: SCL high, SDA released
    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Waits n falling edges of the system clock
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // One SCL period of 8 clocks: data set while low, sampled while high
    task automatic pulse(input logic bit_v, output logic got);
        scl_o = 1'b0;
        step(5);
        sda_oe_o = ~bit_v;
        step(1);
        scl_o = 1'b1;
        step(1);
        got = sda_i;
        step(1);
    endtask
    // Start, also usable as a repeated start
    task automatic start();
        scl_o = 1'b0;
        step(6);
        sda_oe_o = 1'b0;
        step(4);
        scl_o = 1'b1;
        step(6);
        sda_oe_o = 1'b1;
        step(6);
    endtask
    // Stop, leaving the bus idle
    task automatic stop();
        scl_o = 1'b0;
        step(6);
        sda_oe_o = 1'b1;
        step(4);
        scl_o = 1'b1;
        step(6);
        sda_oe_o = 1'b0;
        step(6);
    endtask
    // Sends a byte MSB first and returns the ack level
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) pulse(b[i], g);
        pulse(1'b1, ack);
    endtask
    // Receives a byte, then acks (ack_v high) or leaves SDA high
    task automatic recv_byte(input logic ack_v, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b1, g);
            b[i] = g;
        end
        pulse(~ack_v, g);
    endtask
    // Dummy clocks until the slave lets SDA rise, nine at most
    task automatic recover(output int n);
        logic g;
        n = 0;
        while (sda_i !== 1'b1 && n < 9) begin
            pulse(1'b1, g);
            n++;
        end
    endtask
endmodule // bus_master_model
`default_nettype wire

// *** dv/two_wire_eeprom_slave_test.sv ***
/* Self-checking bench: address decode, page writes with wrap, read-back,
   refusal while busy, standby and bus recovery.
   Assumes bus_master_model as the far side and a 20 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin \
    checked++; \
    if ((act) !== (exp)) begin \
        n_errors++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (act), (exp)); \
    end \
end
module two_wire_eeprom_slave_test;
    localparam int PROG = 400;
    logic       clk, rst, strap_hi, strap_lo, ack;
    logic       scl, m_oe, d_sda, d_oe, standby, busy;
    logic [7:0] d;
    logic [7:0] mem [512];  // Expected array contents
    logic [8:0] addrs [$];
    int         n_errors, checked, k9;
    wire        sda = !((d_oe && !d_sda) || m_oe);  // Pull-up wire
////////////////////////////////////////
    two_wire_eeprom_slave #(.PROGRAM_CYCLES(PROG)) dut_u (
        .clk_i(clk), .rst_i(rst), .strap_addr_high_i(strap_hi),
        .strap_addr_low_i(strap_lo), .scl_i(scl), .sda_i(sda), .sda_o(d_sda),
        .sda_oe_o(d_oe), .standby_o(standby), .busy_o(busy));
    bus_master_model m_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
////////////////////////////////////////
    // Ack level expected for an address byte: low on identifier and strap match
    function automatic logic exp_ack(input logic [7:0] a);
        return !(a[7:4] == 4'ha && a[3] == strap_hi && a[2] == strap_lo);
    endfunction
    // Location of the i-th byte of a write, wrapping inside the page
    function automatic logic [8:0] wrap(input logic [8:0] a, input int i);
        return {a[8:4], a[3:0] + 4'(i)};
    endfunction
    // Start plus address byte, checking the ack level
    task automatic addr(input logic [7:0] a, input logic e);
        m_u.start();
        m_u.send_byte(a, ack);
        `CHK(ack, e)
    endtask
    // Waits at most n clocks for a status level
    task automatic wait_for(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++) @(negedge clk);
    endtask
    // Page write, then a refused poll while programming runs
    task automatic write_page(input logic [8:0] a, input int n);
        addr({4'ha, strap_hi, strap_lo, a[8], 1'b0}, 1'b0);
        m_u.send_byte(a[7:0], ack);
        `CHK(ack, 1'b0)
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            mem[wrap(a, i)] = d;
            addrs.push_back(wrap(a, i));
            m_u.send_byte(d, ack);
            `CHK(ack, 1'b0)
        end
        m_u.stop();
        wait_for(busy, 1'b1, 10);
        `CHK(busy, 1'b1)
        addr({4'ha, strap_hi, strap_lo, 2'b00}, 1'b1);
        m_u.stop();
        wait_for(standby, 1'b1, 2 * PROG);
        `CHK(busy, 1'b0)
        `CHK(standby, 1'b1)
    endtask
    // Random read of one location, ended by the master leaving SDA high
    task automatic read_at(input logic [8:0] a);
        addr({4'ha, strap_hi, strap_lo, a[8], 1'b0}, 1'b0);
        m_u.send_byte(a[7:0], ack);
        addr({4'ha, strap_hi, strap_lo, a[8], 1'b1}, 1'b0);
        m_u.recv_byte(1'b0, d);
        `CHK(d, mem[a])
        `CHK(d_oe, 1'b0)
        m_u.stop();
        wait_for(standby, 1'b1, 10);
        `CHK(standby, 1'b1)
        `CHK(busy, 1'b0)
    endtask
    // Verdict and end of run
    task automatic close_out();
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
////////////////////////////////////////
    // System clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Watchdog against a hung handshake
    initial begin
        #4_000_000;
        n_errors++;
        close_out();
    end
    // Main sequence
    initial begin
        n_errors = 0;
        checked  = 0;
        rst      = 1'b1;
        strap_hi = 1'b0;
        strap_lo = 1'b0;
        void'($urandom(32'h9ea6));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        `CHK(standby, 1'b1)
        `CHK(d_oe, 1'b0)
        `CHK(d_sda, 1'b0)
        repeat (2) @(negedge clk);
        // Every identifier, then random strap bits against random strap pins, each closed by Stop
        for (int k = 0; k < 28; k++) begin
            strap_hi = 1'($urandom);
            strap_lo = 1'($urandom);
            d = (k < 16) ? {4'(k), strap_hi, strap_lo, 2'b00} : {4'ha, 3'($urandom), 1'b0};
            addr(d, exp_ack(d));
            if (ack === 1'b1) begin
                m_u.send_byte(8'($urandom), ack);
                `CHK(ack, 1'b1)
            end
            m_u.stop();
            wait_for(standby, 1'b1, 10);
            `CHK(standby, 1'b1)
        end
        // Wrap from mid page, byte write, wrap at the last slot, random page
        strap_hi = 1'b1;
        strap_lo = 1'b0;
        write_page(9'h1f5, 16);
        write_page(9'h100, 1);
        write_page(9'h0ff, 2);
        write_page(9'($urandom), 1 + int'($urandom % 16));
        foreach (addrs[i]) read_at(addrs[i]);
        // Recovery after an abort while the slave holds its ack
        addr({4'ha, strap_hi, strap_lo, 2'b00}, 1'b0);
        m_u.recover(k9);
        `CHK(sda, 1'b1)
        `CHK(k9 <= 9, 1'b1)
        read_at(addrs[0]);
        close_out();
    end
endmodule // two_wire_eeprom_slave_test
`default_nettype wire
